//--- design/psr_cfg.svh
// Purpose: constants for the port strap loader and pin role block
// Assumes: single 100 MHz core clock
// Notes: strap sample delay counted in core cycles
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
// ****************************************
// timing
// ****************************************
`define PSR_SETTLE_NS 100
`define PSR_CLK_NS 10
`define PSR_SETTLE_CYC ((`PSR_SETTLE_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
// ****************************************
// strap vector field positions
// ****************************************
`define PSR_B_P1_DPX 0
`define PSR_B_P2_AN 1
`define PSR_B_P2_SPD 2
`define PSR_B_P2_DPX 3
`define PSR_B_P2_FC 4
`define PSR_B_P1_FC 5
`define PSR_B_P1_AN 6
`define PSR_B_P1_SPD 7
`define PSR_STRAP_W 8
// ****************************************
// management modes
// ****************************************
`define PSR_MGMT_SPI 2'h0
`define PSR_MGMT_I2C_CLIENT 2'h1
`define PSR_MGMT_I2C_HOST 2'h2
`define PSR_MGMT_MIIM 2'h3
`endif

//--- design/psr_pkg.sv
// Purpose: types for the port strap loader
// Assumes: constants live in psr_cfg.svh
// Notes: none
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_RESET = 2'h0,
    PSR_SETTLE = 2'h1,
    PSR_RUN = 2'h3
  } psr_state_e;
  typedef struct packed {
    logic an_en;
    logic speed_100;
    logic full_duplex;
    logic force_fc;
  } psr_port_cfg_s;
endpackage : psr_pkg

//--- design/psr_port_decode.sv
// Purpose: turns one port's strap levels into its configuration
// Assumes: strap high means pull-up
// Notes: purely combinational
`timescale 1ns/100ps
module psr_port_decode (
  psr_strap_if.dec s
);
  // ****************************************
  // decode
  // ****************************************
  // speed strap only matters when autoneg is off; duplex is fallback or forced
  always_comb begin
    s.cfg.an_en = s.an_strap;
    s.cfg.speed_100 = s.speed_strap;
    s.cfg.full_duplex = s.duplex_strap;
    s.cfg.force_fc = s.fc_strap;
  end
endmodule : psr_port_decode

//--- design/psr_strap_if.sv
// Purpose: carries one port's strap levels to its decoder
// Assumes: levels are synchronous to i_clk
// Notes: none
`timescale 1ns/100ps
interface psr_strap_if;
  logic an_strap;
  logic speed_strap;
  logic duplex_strap;
  logic fc_strap;
  psr_pkg::psr_port_cfg_s cfg;
  modport src (output an_strap, output speed_strap, output duplex_strap, output fc_strap,
    input cfg);
  modport dec (input an_strap, input speed_strap, input duplex_strap, input fc_strap,
    output cfg);
endinterface : psr_strap_if

//--- design/psr_strap_pins.sv
// Purpose: strap capture and pin role control for the port 3 receive pins
// Assumes: pin inputs synchronous to i_clk; strap pins sensed through io inputs
// Notes: straps latched once after reset release, then pins take signal roles
// Notes on behaviour
// - port 1 duplex strap: high full, low half, fallback or forced
// - receive bit three strap high enables port 2 autoneg
// - port 2 speed strap forces 100 or 10 when autoneg off
// - port 2 duplex strap: high full, low half, fallback or forced
// - port 2 pause strap high forces flow control, low follows autoneg
// - serial read pin strap high forces port 1 flow control
// - host_irq_n low whenever an enabled link-loss status bit is set
// - receive clock pin output in PHY MII mode without the RMII variant, input in MAC mode or the RMII variant
// - management clock input except in I2C host mode
// - management data input in SPI, two-way otherwise
// - serial read data driven on its pin in SPI client mode
// - RMII variant drives reference clock on receive bit three pin
// - valid plus four bits in MII; in RMII bits zero and one carry data, bit two idles low, bit three the reference clock
// - collision and carrier sense driven toward the MAC
// - port 1 autoneg strap high enables, low disables
// - port 1 speed strap forces 100 or 10 when autoneg off
`timescale 1ns/100ps
`include "psr_cfg.svh"
module psr_strap_pins #(
  parameter int SETTLE_CYC = `PSR_SETTLE_CYC
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // mode selection
  input wire logic i_rmii_variant,
  input wire logic i_phy_mii_mode,
  input wire logic [1:0] i_mgmt_mode,
  // pin levels sensed during strap
  input wire logic i_p3_rx_valid_pin,
  input wire logic [3:0] i_p3_rx_bits_pin,
  input wire logic i_serial_read_out_pin,
  input wire logic i_first_port_autoneg_strap,
  input wire logic i_first_port_speed_strap,
  // core receive side toward port 3
  input wire logic i_core_rx_valid,
  input wire logic [3:0] i_core_rx_bits,
  input wire logic i_core_rx_clock,
  input wire logic i_core_collision,
  input wire logic i_core_carrier_sense,
  input wire logic i_ref_clock,
  // management core signals
  input wire logic i_serial_read_data,
  input wire logic i_spi_select_n,
  input wire logic i_i2c_host_clock,
  input wire logic i_mgmt_data_out,
  input wire logic i_mgmt_data_oe,
  // link-loss status and enable
  input wire logic [1:0] i_link_loss_status,
  input wire logic [1:0] i_link_loss_enable,
  // port 3 receive pins
  output logic o_p3_rx_valid,
  output logic o_p3_rx_valid_oe,
  output logic [3:0] o_p3_rx_bits,
  output logic [3:0] o_p3_rx_bits_oe,
  output logic o_p3_rx_clock,
  output logic o_p3_rx_clock_oe,
  output logic o_p3_collision,
  output logic o_p3_carrier_sense,
  // management pins
  output logic o_mgmt_clock,
  output logic o_mgmt_clock_oe,
  output logic o_mgmt_data,
  output logic o_mgmt_data_oe,
  output logic o_serial_read_out,
  output logic o_serial_read_out_oe,
  // host interrupt
  output logic o_host_irq_n,
  // captured configuration
  output logic o_cfg_valid,
  output psr_pkg::psr_port_cfg_s o_port1_cfg,
  output psr_pkg::psr_port_cfg_s o_port2_cfg
);
  // refuse settle counts that the 16-bit counter cannot serve
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  psr_pkg::psr_state_e state_r;
  logic [15:0] cnt_r;
  logic [`PSR_STRAP_W-1:0] strap_r;
  logic run;
  psr_strap_if p1_if ();
  psr_strap_if p2_if ();

  assign run = (state_r == psr_pkg::PSR_RUN);

  // ****************************************
  // strap capture sequence
  // ****************************************
  // settle after release, latch once, then drive pins in their roles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= psr_pkg::PSR_RESET;
      cnt_r <= 16'h0000;
    end else if (i_ce) begin
      unique case (state_r)
        psr_pkg::PSR_RESET: begin
          state_r <= psr_pkg::PSR_SETTLE;
          cnt_r <= 16'h0000;
        end
        psr_pkg::PSR_SETTLE: begin
          if (cnt_r == 16'(SETTLE_CYC - 1)) state_r <= psr_pkg::PSR_RUN;
          cnt_r <= cnt_r + 16'h0001;
        end
        psr_pkg::PSR_RUN: state_r <= psr_pkg::PSR_RUN;
        default: state_r <= psr_pkg::PSR_RESET;
      endcase
    end
  end

  // sample strap levels at the last settle cycle only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_r <= '0;
    end else if (i_ce && state_r == psr_pkg::PSR_SETTLE && cnt_r == 16'(SETTLE_CYC - 1)) begin
      strap_r[`PSR_B_P1_DPX] <= i_p3_rx_valid_pin;
      strap_r[`PSR_B_P2_AN] <= i_p3_rx_bits_pin[3];
      strap_r[`PSR_B_P2_SPD] <= i_p3_rx_bits_pin[2];
      strap_r[`PSR_B_P2_DPX] <= i_p3_rx_bits_pin[1];
      strap_r[`PSR_B_P2_FC] <= i_p3_rx_bits_pin[0];
      strap_r[`PSR_B_P1_FC] <= i_serial_read_out_pin;
      strap_r[`PSR_B_P1_AN] <= i_first_port_autoneg_strap;
      strap_r[`PSR_B_P1_SPD] <= i_first_port_speed_strap;
    end
  end

  // ****************************************
  // per-port decode
  // ****************************************
  assign p1_if.an_strap = strap_r[`PSR_B_P1_AN];
  assign p1_if.speed_strap = strap_r[`PSR_B_P1_SPD];
  assign p1_if.duplex_strap = strap_r[`PSR_B_P1_DPX];
  assign p1_if.fc_strap = strap_r[`PSR_B_P1_FC];
  assign p2_if.an_strap = strap_r[`PSR_B_P2_AN];
  assign p2_if.speed_strap = strap_r[`PSR_B_P2_SPD];
  assign p2_if.duplex_strap = strap_r[`PSR_B_P2_DPX];
  assign p2_if.fc_strap = strap_r[`PSR_B_P2_FC];

  psr_port_decode u_p1 (.s(p1_if));
  psr_port_decode u_p2 (.s(p2_if));

  // registered configuration outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_valid <= 1'b0;
      o_port1_cfg <= '0;
      o_port2_cfg <= '0;
    end else if (i_ce) begin
      o_cfg_valid <= run;
      o_port1_cfg <= p1_if.cfg;
      o_port2_cfg <= p2_if.cfg;
    end
  end

  // ****************************************
  // port 3 receive pins
  // ****************************************
  // pins stay released until straps are latched
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_p3_rx_valid <= 1'b0;
      o_p3_rx_valid_oe <= 1'b0;
      o_p3_rx_bits <= 4'h0;
      o_p3_rx_bits_oe <= 4'h0;
      o_p3_collision <= 1'b0;
      o_p3_carrier_sense <= 1'b0;
    end else if (i_ce) begin
      o_p3_rx_valid <= run & i_core_rx_valid;
      o_p3_rx_valid_oe <= run;
      o_p3_collision <= run & i_core_collision;
      o_p3_carrier_sense <= run & i_core_carrier_sense;
      if (i_rmii_variant) begin
        // bit three becomes the reference clock, bit two idles low
        o_p3_rx_bits <= {i_ref_clock, 1'b0, i_core_rx_bits[1:0]};
        o_p3_rx_bits_oe <= {4{run}};
      end else begin
        o_p3_rx_bits <= i_core_rx_bits;
        o_p3_rx_bits_oe <= {4{run}};
      end
    end
  end

  // receive clock direction depends on MII role
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_p3_rx_clock <= 1'b0;
      o_p3_rx_clock_oe <= 1'b0;
    end else if (i_ce) begin
      o_p3_rx_clock <= i_core_rx_clock;
      o_p3_rx_clock_oe <= run & i_phy_mii_mode & ~i_rmii_variant;
    end
  end

  // ****************************************
  // management pins
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mgmt_clock <= 1'b0;
      o_mgmt_clock_oe <= 1'b0;
      o_mgmt_data <= 1'b0;
      o_mgmt_data_oe <= 1'b0;
      o_serial_read_out <= 1'b0;
      o_serial_read_out_oe <= 1'b0;
    end else if (i_ce) begin
      o_mgmt_clock <= i_i2c_host_clock;
      o_mgmt_clock_oe <= run & (i_mgmt_mode == `PSR_MGMT_I2C_HOST);
      // open-drain style: drive only low, pull-up supplies high
      o_mgmt_data <= 1'b0;
      o_mgmt_data_oe <= run & (i_mgmt_mode != `PSR_MGMT_SPI)
        & i_mgmt_data_oe & ~i_mgmt_data_out;
      o_serial_read_out <= i_serial_read_data;
      o_serial_read_out_oe <= run & (i_mgmt_mode == `PSR_MGMT_SPI)
        & ~i_spi_select_n;
    end
  end

  // ****************************************
  // host interrupt
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_irq_n <= 1'b1;
    end else if (i_ce) begin
      o_host_irq_n <= ~|(i_link_loss_status & i_link_loss_enable);
    end
  end
endmodule : psr_strap_pins

//--- testbench/psr_host_model.sv
// Purpose: strap resistors and pin wires facing the block
// Assumes: each strap pin has a pull resistor
// Notes: a released pin shows its resistor level
`timescale 1ns/100ps
module psr_host_model (
  // strap resistors, {read out, valid, bits}
  input wire logic [5:0] i_pull,
  // device drive
  input wire logic i_valid, i_valid_oe, i_sq, i_sq_oe,
  input wire logic [3:0] i_bits, i_bits_oe,
  // resolved wire levels
  output logic o_valid_lvl, o_sq_lvl,
  output logic [3:0] o_bits_lvl
);
  // device drive wins, else the resistor
  assign o_valid_lvl = i_valid_oe ? i_valid : i_pull[4];
  assign o_bits_lvl = (i_bits & i_bits_oe) | (i_pull[3:0] & ~i_bits_oe);
  assign o_sq_lvl = i_sq_oe ? i_sq : i_pull[5];
endmodule : psr_host_model

//--- testbench/psr_sp_checker.sv
// Purpose: port assertions for the strap and pin role block
// Assumes: assertions step only on edges where the clock enable is high
// Notes: bound to the top module
`timescale 1ns/100ps
module psr_sp_checker #(parameter int SETTLE_CYC = 10) (
  input wire logic i_clk, i_rst, i_ce, i_rmii_variant, i_phy_mii_mode, i_spi_select_n, i_ref_clock,
  input wire logic i_mgmt_data_out, i_mgmt_data_oe, o_mgmt_data_oe,
  input wire logic i_p3_rx_valid_pin, i_serial_read_out_pin, i_first_port_autoneg_strap,
  input wire logic i_first_port_speed_strap, o_p3_rx_clock_oe, o_mgmt_clock_oe,
  input wire logic o_serial_read_out_oe, o_host_irq_n, o_cfg_valid,
  input wire logic [1:0] i_mgmt_mode, i_link_loss_status, i_link_loss_enable,
  input wire logic [3:0] i_p3_rx_bits_pin, i_core_rx_bits, o_p3_rx_bits, o_p3_rx_bits_oe,
  input wire psr_pkg::psr_port_cfg_s o_port1_cfg, o_port2_cfg
);
  // the block only moves on enabled edges, so the checker steps on those alone
  default clocking @(posedge i_clk iff i_ce); endclocking
  default disable iff (i_rst);
  // pin roles, interrupt and capture
  irq_follows_a: assert property (!$past(i_rst) |-> o_host_irq_n ==
    ~|($past(i_link_loss_status) & $past(i_link_loss_enable))) else $error("irq wrong");
  rclk_role_a: assert property (o_cfg_valid && $past(o_cfg_valid) |->
    o_p3_rx_clock_oe == ($past(i_phy_mii_mode) & !$past(i_rmii_variant))) else $error("rclk");
  mclk_role_a: assert property (o_cfg_valid && $past(o_cfg_valid) |->
    o_mgmt_clock_oe == ($past(i_mgmt_mode) == 2'h2)) else $error("mclk oe wrong");
  mdata_role_a: assert property (o_cfg_valid && $past(o_cfg_valid) |->
    o_mgmt_data_oe == ($past(i_mgmt_mode) != 2'h0 && $past(i_mgmt_data_oe) &&
    !$past(i_mgmt_data_out))) else $error("mdata oe wrong");
  sq_role_a: assert property (o_cfg_valid && $past(o_cfg_valid) |->
    o_serial_read_out_oe == ($past(i_mgmt_mode) == 2'h0 && !$past(i_spi_select_n)))
    else $error("sq oe wrong");
  rmii_bits_a: assert property (o_cfg_valid && $past(o_cfg_valid) &&
    $past(i_rmii_variant) |-> o_p3_rx_bits == {$past(i_ref_clock), 1'b0,
    2'($past(i_core_rx_bits))}) else $error("rmii");
  oe_quiet_a: assert property (!o_cfg_valid |-> o_p3_rx_bits_oe == 4'h0 &&
    !o_p3_rx_clock_oe && !o_serial_read_out_oe) else $error("oe before run");
  cfg_capture_a: assert property ($rose(o_cfg_valid) |->
    o_port2_cfg == $past(i_p3_rx_bits_pin) && o_port1_cfg == {$past(i_first_port_autoneg_strap),
    $past(i_first_port_speed_strap), $past(i_p3_rx_valid_pin), $past(i_serial_read_out_pin)})
    else $error("capture wrong");
  cfg_hold_a: assert property (o_cfg_valid && $past(o_cfg_valid) |->
    $stable(o_port1_cfg) && $stable(o_port2_cfg)) else $error("cfg moved");
endmodule : psr_sp_checker
bind psr_strap_pins psr_sp_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.*);

//--- testbench/psr_strap_pins_tb.sv
// Purpose: self-checking bench for the strap and pin role block
// Assumes: pin straps come through the host model wires; port 1 autoneg and speed straps are driven directly
// Notes: short settle count
`timescale 1ns/100ps
module psr_strap_pins_tb;
  localparam int N = 2;
  logic i_clk = 0, i_rst = 1, rmii = 0, phy = 0, sel_n = 1, dout = 0, doe = 0;
  logic p1an = 0, first_port_speed_strap = 0, cv = 0, cc = 0, cs = 0, rf = 0, ce = 1, rc = 0, hc = 0, sd = 0;
  logic [1:0] mode = 0, st = 0, en = 0;
  logic [3:0] cb = 0, ob, oboe, lb, eb;
  logic [5:0] pull = 0;
  logic ov, ovoe, orcoe, ocol, ocrs, omcoe, omdoe, osq, osqoe, oirq, ocfgv, lv, lsq;
  logic orc, omc, omd;
  psr_pkg::psr_port_cfg_s p1c, p2c;
  int n_mismatch = 0, n_tests = 0;
  // row inputs {mode, sel_n, phy, rmii, dout, doe, st, en}, outputs {rclk, mclk, md, sq oe, irq}
  logic [8:0] rin [5] = '{9'h027, 9'h0F6, 9'h10D, 9'h1A3, 9'h1D4};
  logic [4:0] rex [5] = '{5'h12, 5'h05, 5'h09, 5'h10, 5'h05};
  initial forever #5 i_clk = ~i_clk;
  psr_strap_pins #(.SETTLE_CYC(N)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
    .i_rmii_variant(rmii), .i_phy_mii_mode(phy), .i_mgmt_mode(mode), .i_p3_rx_valid_pin(lv),
    .i_p3_rx_bits_pin(lb), .i_serial_read_out_pin(lsq), .i_first_port_autoneg_strap(p1an),
    .i_first_port_speed_strap(first_port_speed_strap), .i_core_rx_valid(cv), .i_core_rx_bits(cb),
    .i_core_rx_clock(rc), .i_core_collision(cc), .i_core_carrier_sense(cs), .i_ref_clock(rf),
    .i_serial_read_data(sd), .i_spi_select_n(sel_n), .i_i2c_host_clock(hc),
    .i_mgmt_data_out(dout), .i_mgmt_data_oe(doe), .i_link_loss_status(st),
    .i_link_loss_enable(en), .o_p3_rx_valid(ov), .o_p3_rx_valid_oe(ovoe), .o_p3_rx_bits(ob),
    .o_p3_rx_bits_oe(oboe), .o_p3_rx_clock(orc), .o_p3_rx_clock_oe(orcoe), .o_p3_collision(ocol),
    .o_p3_carrier_sense(ocrs), .o_mgmt_clock(omc), .o_mgmt_clock_oe(omcoe), .o_mgmt_data(omd),
    .o_mgmt_data_oe(omdoe), .o_serial_read_out(osq), .o_serial_read_out_oe(osqoe),
    .o_host_irq_n(oirq), .o_cfg_valid(ocfgv), .o_port1_cfg(p1c), .o_port2_cfg(p2c));
  psr_host_model host (.i_pull(pull), .i_valid(ov), .i_valid_oe(ovoe), .i_sq(osq),
    .i_sq_oe(osqoe), .i_bits(ob), .i_bits_oe(oboe), .o_valid_lvl(lv), .o_sq_lvl(lsq),
    .o_bits_lvl(lb));
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // reset with strap set s = {p1an, first_port_speed_strap, pull}, then capture
  task automatic boot(input logic [7:0] s);
    int k;
    @(posedge i_clk);
    i_rst <= 1;
    {p1an, first_port_speed_strap, pull} <= s;
    repeat (5) @(posedge i_clk);
    chk({oirq, ocfgv, orcoe, osqoe, oboe}, 16'h0080);
    i_rst <= 0;
    k = 0;
    while (ocfgv !== 1'b1 && k < 50) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    if (ocfgv !== 1'b1) begin
      n_mismatch++;
      tally_and_finish;
    end
    chk(16'(k), 16'(N + 2));
    chk({p1c, p2c}, {s[7:6], s[4], s[5], s[3:0]});
    // flip every resistor after capture: the latched set must not move
    @(posedge i_clk);
    pull <= ~s[5:0];
    repeat (2) @(posedge i_clk);
    #1;
    chk({p1c, p2c}, {s[7:6], s[4], s[5], s[3:0]});
  endtask : boot
  initial begin
    boot(8'h8A);
    // pin role rows
    for (int r = 0; r < 5; r++) begin
      @(posedge i_clk);
      {mode, sel_n, phy, rmii, dout, doe, st[0], en[0]} <= rin[r];
      cb <= 4'(r * 3 + 5);
      {cv, cc, cs, rf} <= 4'(r + 6);
      {rc, hc, sd} <= 3'(r + 3);
      @(posedge i_clk);
      #1;
      eb = rmii ? {rf, 1'b0, cb[1:0]} : cb;
      chk({orcoe, omcoe, omdoe, osqoe, oirq}, rex[r]);
      chk({orc, omc, omd, osq}, {rc, hc, 1'b0, sd});
      chk({ob, ov, ovoe, ocol, ocrs, oboe}, {eb, cv, 1'b1, cc, cs, 4'hF});
    end
    // reset again in mid-run with the opposite straps
    boot(8'h75);
    // masked, unmasked, then cleared link loss on the upper port
    @(posedge i_clk);
    {st, en} <= 4'h9;
    @(posedge i_clk);
    #1;
    chk(oirq, 1'b1);
    @(posedge i_clk);
    en <= 2'h3;
    @(posedge i_clk);
    #1;
    chk(oirq, 1'b0);
    @(posedge i_clk);
    st <= 2'h0;
    @(posedge i_clk);
    #1;
    chk(oirq, 1'b1);
    // enable low freezes the output, which catches up once it returns
    @(posedge i_clk);
    {ce, st} <= 3'h3;
    repeat (2) @(posedge i_clk);
    #1;
    chk(oirq, 1'b1);
    @(posedge i_clk);
    ce <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(oirq, 1'b0);
    tally_and_finish;
  end
endmodule : psr_strap_pins_tb
